//--- verilog/prm_matrix.sv
// Purpose: Routes protection signals to five contacts and eight indicators
// Assumes: Protection element outputs are synchronous to ref_clk
// Notes:   A switch word read back equals its checksum
`timescale 1ns/1ps
`default_nettype none
module prm_matrix
  import prm_pkg::*;
#(
  parameter logic [CYC_CNT_W-1:0] CYC_PER_MIN = CYC_CNT_W'(CYCLES_PER_MIN)
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Protection signals and trip targets
  input  wire prm_signals_type     sig_in,
  input  wire prm_trip_type        trip_in,
  // Contact and indicator drivers
  output logic [NUM_CONTACTS-1:0]  contact_out,
  output logic [NUM_LEDS-1:0]      led_out,
  // Trip target display
  output logic                     target_shown,
  output logic [TARGET_W-1:0]      target_code
);

  logic                    rst_sync1_reg;
  logic                    rst_sync2_reg;
  logic                    rst_n;
  logic [CONTACT_SW_W-1:0] cmap_reg [NUM_CONTACTS];
  logic [LED_SW_W-1:0]     lmap_reg [NUM_LEDS];
  logic [HOLD_W-1:0]       hold_reg;
  logic                    rd_pc3_reg;
  logic [NUM_CONTACTS-1:0] contact_reg;
  logic [NUM_LEDS-1:0]     led_reg;
  logic                    shown_reg;
  logic [TARGET_W-1:0]     code_reg;
  logic [31:0]             prdata_reg;
  logic                    pready_reg;
  logic                    pslverr_reg;
  logic                    access;
  logic                    wr_en;
  logic                    hold_expired;
  logic                    take_target;
  logic [31:0]             rd_data_next;
  logic                    rd_err_next;

  function automatic logic addr_in(input logic [7:0] a, input logic [7:0] base,
                                   input int unsigned n);
    return (a >= base) && (a < base + 8'(4 * n)) && (a[1:0] == 2'b00);
  endfunction : addr_in

  function automatic int unsigned word_idx(input logic [7:0] a, input logic [7:0] base);
    return int'(8'(a - base) >> 2);
  endfunction : word_idx

  // Reset release synchroniser
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  // APB: one wait state, answer on second access cycle
  assign access = psel && penable && !pready_reg;
  assign wr_en  = psel && penable && pready_reg && pwrite && !pslverr_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= access;
    end
  end

  // Switch words
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmap_reg[0] <= RST_POWER_TRIP;
      cmap_reg[1] <= RST_POWER_TRIP;
      cmap_reg[2] <= RST_POWER_EMPTY;
      cmap_reg[3] <= RST_SIGNAL;
      cmap_reg[4] <= RST_SIGNAL;
    end else if (wr_en && addr_in(paddr, OFS_CONTACT_BASE, NUM_CONTACTS)) begin
      cmap_reg[word_idx(paddr, OFS_CONTACT_BASE)] <= pwdata[CONTACT_SW_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_LEDS; i++) begin
        lmap_reg[i] <= (i == 0) ? RST_LED1 : (i == 1) ? RST_LED2 : RST_LED_OTHER;
      end
    end else if (wr_en && addr_in(paddr, OFS_LED_BASE, NUM_LEDS)) begin
      lmap_reg[word_idx(paddr, OFS_LED_BASE)] <= pwdata[LED_SW_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg   <= RST_HOLD_TIME;
      rd_pc3_reg <= 1'b0;
    end else if (wr_en && paddr == OFS_HOLD_TIME) begin
      hold_reg <= pwdata[HOLD_W-1:0];
    end else if (wr_en && paddr == OFS_CONTROL) begin
      rd_pc3_reg <= pwdata[CTRL_RD_TO_PC3_BIT];
    end
  end

  // Read mux; word value is its checksum with weight 2**(n-1)
  always_comb begin
    rd_data_next = 32'h0;
    rd_err_next  = 1'b0;
    if (addr_in(paddr, OFS_CONTACT_BASE, NUM_CONTACTS)) begin
      rd_data_next = 32'(cmap_reg[word_idx(paddr, OFS_CONTACT_BASE)]);
    end else if (addr_in(paddr, OFS_LED_BASE, NUM_LEDS)) begin
      rd_data_next = 32'(lmap_reg[word_idx(paddr, OFS_LED_BASE)]);
    end else if (paddr == OFS_HOLD_TIME) begin
      rd_data_next = 32'(hold_reg);
    end else if (paddr == OFS_CONTROL) begin
      rd_data_next = 32'(rd_pc3_reg);
    end else if (paddr == OFS_STATUS) begin
      rd_data_next = {19'h0, led_reg, contact_reg};
    end else if (paddr == OFS_TARGET) begin
      rd_data_next = {23'h0, shown_reg, code_reg};
    end else begin
      rd_err_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else if (access) begin
      prdata_reg  <= pwrite ? 32'h0 : rd_data_next;
      pslverr_reg <= rd_err_next;
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  // Contact routing, independent of the hold setting
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      contact_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_CONTACTS; i++) begin
        contact_reg[i] <= |(cmap_reg[i] & sig_in.contact_src);
      end
      if (rd_pc3_reg) begin
        contact_reg[2] <= sig_in.restart_disable;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_LEDS; i++) begin
        led_reg[i] <= |(lmap_reg[i] & sig_in.led_src);
      end
    end
  end

  // Trip target display
  assign take_target = trip_in.trip_valid && (!shown_reg || trip_in.manual_clear || hold_expired);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shown_reg <= 1'b0;
      code_reg  <= '0;
    end else if (take_target) begin
      shown_reg <= 1'b1;
      code_reg  <= trip_in.trip_code;
    end else if (trip_in.manual_clear) begin
      shown_reg <= 1'b0;
    end
  end

  // Timer restarts on every take, so each shown target gets a full hold
  prm_hold_timer #(
    .CYC_PER_MIN (CYC_PER_MIN)
  ) u_hold_timer (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .start    (take_target),
    .hold_min (hold_reg),
    .expired  (hold_expired)
  );

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign contact_out  = contact_reg;
  assign led_out      = led_reg;
  assign target_shown = shown_reg;
  assign target_code  = code_reg;

  AST_PC1_OR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    contact_out[0] == $past(|(cmap_reg[0] & sig_in.contact_src)))
    else $error("power contact 1 not OR of selected signals");

  AST_SC2_OR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    contact_out[4] == $past(|(cmap_reg[4] & sig_in.contact_src)))
    else $error("signal contact 2 not driven by fifth word");

  AST_PC3_OVR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rd_pc3_reg) |-> contact_out[2] == $past(sig_in.restart_disable))
    else $error("restart disable did not override third power contact");

  AST_LED_OR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    led_out[7] == $past(|(lmap_reg[7] & sig_in.led_src)))
    else $error("indicator 8 not OR of its word");

  AST_HOLD_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    shown_reg && !hold_expired && !trip_in.manual_clear |=> $stable(code_reg))
    else $error("trip target replaced before hold expired");

  AST_BLOCK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hold_reg >= HOLD_BLOCK |-> !hold_expired)
    else $error("hold timer expired under block setting");

  AST_TAKE_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !shown_reg && trip_in.trip_valid |=> shown_reg && code_reg == $past(trip_in.trip_code))
    else $error("first trip target not displayed");

  AST_APB_ONE_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && !penable ##1 psel && penable |=> pready ##1 !pready)
    else $error("APB answer not after one wait state");

  AST_ZERO_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hold_reg == 10'h000 && $stable(hold_reg) && !take_target && !$past(take_target)
    |-> hold_expired)
    else $error("zero hold time did not allow replacement");

  // Remaining contacts, indicators 1 and 2, bus answers and display updates
  AST_PC2_OR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    contact_out[1] ==
      $past(|(cmap_reg[1] & sig_in.contact_src)))
    else $error("power contact 2 not driven by second word");

  AST_PC3_OR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(rd_pc3_reg) |->
      contact_out[2] == $past(|(cmap_reg[2] & sig_in.contact_src)))
    else $error("power contact 3 not OR of selected signals");

  AST_SC1_OR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    contact_out[3] ==
      $past(|(cmap_reg[3] & sig_in.contact_src)))
    else $error("signal contact 1 not driven by fourth word");

  AST_LED1_OR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    led_out[0] ==
      $past(|(lmap_reg[0] & sig_in.led_src)))
    else $error("indicator 1 not OR of its word");

  AST_LED2_OR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    led_out[1] ==
      $past(|(lmap_reg[1] & sig_in.led_src)))
    else $error("indicator 2 not OR of its word");

  AST_CW_WIDTH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && penable && pready && !pwrite && addr_in(paddr, OFS_CONTACT_BASE, NUM_CONTACTS)
    |-> prdata[31:CONTACT_SW_W] == '0)
    else $error("contact word read shows bits above nineteen switches");

  AST_LW_WIDTH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && penable && pready && !pwrite && addr_in(paddr, OFS_LED_BASE, NUM_LEDS)
    |-> prdata[31:LED_SW_W] == '0)
    else $error("indicator word read shows bits above twenty-two switches");

  AST_PREADY_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pready
    |=> !pready)
    else $error("bus answer lasted more than one cycle");

  AST_ERR_WITH_READY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pslverr
    |-> pready)
    else $error("bus error shown without an answer");

  AST_ERR_NO_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && penable && pready && pwrite && pslverr
    |=> $stable(cmap_reg[0]) && $stable(lmap_reg[0]) && $stable(hold_reg))
    else $error("refused write changed a setting");

  AST_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    trip_in.manual_clear && !trip_in.trip_valid
    |=> !shown_reg)
    else $error("manual clear did not remove the shown target");

  AST_REPLACE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    shown_reg && hold_expired && trip_in.trip_valid
    |=> shown_reg && code_reg == $past(trip_in.trip_code))
    else $error("newer trip target not shown after hold expired");

  AST_RESTART_TIMER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take_target
    |=> !hold_expired)
    else $error("hold timer not restarted by a new target");

  AST_HOLD_WR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && penable && pready && pwrite && !pslverr && paddr == OFS_HOLD_TIME
    |=> hold_reg == $past(pwdata[HOLD_W-1:0]))
    else $error("hold setting write did not land");

  AST_CTRL_WR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && penable && pready && pwrite && !pslverr && paddr == OFS_CONTROL
    |=> rd_pc3_reg == $past(pwdata[CTRL_RD_TO_PC3_BIT]))
    else $error("restart disable routing write did not land");

endmodule : prm_matrix
`default_nettype wire

//--- shared/prm_pkg.sv
// Purpose: Shared constants and types for the protection signal routing matrix
// Assumes: 32-bit APB register access, 200 MHz ref_clk
// Notes:   Switch word bit n-1 holds switch position n
package prm_pkg;

  localparam int unsigned CONTACT_SW_W   = 19;
  localparam int unsigned LED_SW_W       = 22;
  localparam int unsigned NUM_CONTACTS   = 5;
  localparam int unsigned NUM_LEDS       = 8;
  localparam int unsigned HOLD_W         = 10;
  localparam int unsigned TARGET_W       = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTACT_BASE = 8'h00;
  localparam logic [7:0] OFS_LED_BASE     = 8'h20;
  localparam logic [7:0] OFS_HOLD_TIME    = 8'h40;
  localparam logic [7:0] OFS_CONTROL      = 8'h44;
  localparam logic [7:0] OFS_STATUS       = 8'h48;
  localparam logic [7:0] OFS_TARGET       = 8'h4c;

  // Reset values and the hold block threshold
  localparam logic [CONTACT_SW_W-1:0] RST_POWER_TRIP  = 19'h01aaa;
  localparam logic [CONTACT_SW_W-1:0] RST_POWER_EMPTY = 19'h00000;
  localparam logic [CONTACT_SW_W-1:0] RST_SIGNAL      = 19'h02555;
  localparam logic [LED_SW_W-1:0]     RST_LED1        = 22'h000004;
  localparam logic [LED_SW_W-1:0]     RST_LED2        = 22'h000008;
  localparam logic [LED_SW_W-1:0]     RST_LED_OTHER   = 22'h000000;
  localparam logic [HOLD_W-1:0]       RST_HOLD_TIME   = 10'h03c;
  localparam logic [HOLD_W-1:0]       HOLD_BLOCK      = 10'h3e7;

  // Control register fields
  localparam int unsigned CTRL_RD_TO_PC3_BIT = 0;

  // Timing
  localparam longint unsigned CLK_HZ          = 64'd200_000_000;
  localparam longint unsigned MINUTE_S        = 64'd60;
  localparam longint unsigned CYCLES_PER_MIN  = CLK_HZ * MINUTE_S;
  localparam int unsigned     CYC_CNT_W       = 34;

  typedef struct packed {
    logic [LED_SW_W-1:0]     led_src;
    logic [CONTACT_SW_W-1:0] contact_src;
    logic                    restart_disable;
  } prm_signals_type;

  typedef struct packed {
    logic                trip_valid;
    logic [TARGET_W-1:0] trip_code;
    logic                manual_clear;
  } prm_trip_type;

endpackage : prm_pkg

//--- verilog/prm_hold_timer.sv
// Purpose: Minute timer that tells when a shown trip target may be replaced
// Assumes: start is a one-cycle pulse when a target is taken
// Notes:   Minute length is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
module prm_hold_timer
  import prm_pkg::*;
#(
  parameter logic [CYC_CNT_W-1:0] CYC_PER_MIN = CYC_CNT_W'(CYCLES_PER_MIN)
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Control
  input  wire logic              start,
  input  wire logic [HOLD_W-1:0] hold_min,
  // Status
  output var  logic              expired
);

  logic [CYC_CNT_W-1:0] cyc_reg;
  logic [HOLD_W-1:0]    min_reg;
  logic                 expired_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg <= '0;
      min_reg <= '0;
    end else if (start) begin
      cyc_reg <= '0;
      min_reg <= '0;
    end else if (cyc_reg == CYC_PER_MIN - 1'b1) begin
      cyc_reg <= '0;
      if (min_reg != {HOLD_W{1'b1}}) begin
        min_reg <= min_reg + 1'b1;
      end
    end else begin
      cyc_reg <= cyc_reg + 1'b1;
    end
  end

  // Settings at or above the block value never expire
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      expired_reg <= 1'b0;
    end else begin
      expired_reg <= !start && (hold_min < HOLD_BLOCK) && (min_reg >= hold_min);
    end
  end

  assign expired = expired_reg && (hold_min < HOLD_BLOCK);

endmodule : prm_hold_timer
`default_nettype wire

//--- verif/prm_far_model.sv
// Purpose: Behavioural output contacts and front-panel lamps driven by the matrix
// Assumes: Drivers are synchronous to the relay clock
// Notes:   Contacts and lamps follow their drivers one cycle late
`timescale 1ns/1ps
`default_nettype none
module prm_far_model
  import prm_pkg::*;
(
  // Clock
  input  wire logic                    clk,
  // Drivers from the matrix
  input  wire logic [NUM_CONTACTS-1:0] contact_drv,
  input  wire logic [NUM_LEDS-1:0]     led_drv,
  // Contact and lamp state
  output var  logic [NUM_CONTACTS-1:0] closed,
  output var  logic [NUM_LEDS-1:0]     lit
);
  // Armature pick-up and lamp warm-up lag the driver by one cycle
  always_ff @(posedge clk) begin
    closed <= contact_drv;
    lit    <= led_drv;
  end
endmodule : prm_far_model
`default_nettype wire

//--- verif/tb_prm_matrix.sv
// Purpose: Self-checking bench for the protection signal routing matrix
// Assumes: One minute shortened to 10 clock cycles
// Notes:   Registers reached over APB; far side is a contact and lamp model
`timescale 1ns/1ps
`default_nettype none
module tb_prm_matrix;
  import prm_pkg::*;
  logic                    ref_clk;
  logic                    arst_n;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  prm_signals_type         sig_in;
  prm_trip_type            trip_in;
  logic [NUM_CONTACTS-1:0] contact_out;
  logic [NUM_LEDS-1:0]     led_out;
  logic                    target_shown;
  logic [TARGET_W-1:0]     target_code;
  logic [NUM_CONTACTS-1:0] closed;
  logic [NUM_LEDS-1:0]     lit;
  int                      err_total;
  int                      checks_done;

  prm_matrix #(.CYC_PER_MIN(34'd10)) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sig_in(sig_in), .trip_in(trip_in), .contact_out(contact_out), .led_out(led_out),
    .target_shown(target_shown), .target_code(target_code)
  );

  prm_far_model far (
    .clk(ref_clk), .contact_drv(contact_out), .led_drv(led_out), .closed(closed), .lit(lit)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      results();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd_chk

  task automatic route(input logic [18:0] cs, input logic [21:0] ls, input logic rd_in,
                       input logic [4:0] ec, input logic [7:0] el);
    @(posedge ref_clk);
    sig_in <= '{led_src: ls, contact_src: cs, restart_disable: rd_in};
    repeat (3) @(posedge ref_clk);
    #1;
    chk({19'h0, contact_out, led_out}, {19'h0, ec, el});
    chk({19'h0, closed, lit}, {19'h0, ec, el});
  endtask : route

  task automatic trip(input logic [7:0] c, input logic m);
    @(posedge ref_clk);
    trip_in <= '{trip_valid: 1'b1, trip_code: c, manual_clear: m};
    @(posedge ref_clk);
    trip_in <= '0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : trip

  task automatic t_reset();
    logic [31:0] ce [5];
    ce = '{32'h1aaa, 32'h1aaa, 32'h0, 32'h2555, 32'h2555};
    for (int i = 0; i < 5; i++) rd_chk(8'(4 * i), ce[i], 1'b0);
    for (int i = 0; i < 8; i++) rd_chk(8'(32 + 4 * i), (i == 0) ? 32'h4 :
                                       (i == 1) ? 32'h8 : 32'h0, 1'b0);
    rd_chk(8'h40, 32'h3c, 1'b0);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_width();
    wr(8'h08, 32'hffffffff);
    rd_chk(8'h08, 32'h7ffff, 1'b0);
    wr(8'h3c, 32'hffffffff);
    rd_chk(8'h3c, 32'h3fffff, 1'b0);
    $display("test switch word width done");
  endtask : t_width

  task automatic t_route();
    for (int i = 0; i < 5; i++) wr(8'(4 * i), 32'h1 << (2 * i));
    for (int i = 0; i < 8; i++) wr(8'(32 + 4 * i), 32'h1 << (i + 10));
    for (int k = 0; k < 8; k++)
      route((k < 5) ? 19'(32'h1 << (2 * k)) : 19'h2, 22'(32'h1 << (k + 10)), 1'b0,
            (k < 5) ? 5'(32'h1 << k) : 5'h0, 8'(32'h1 << k));
    route(19'h7ffff, 22'h3fffff, 1'b0, 5'h1f, 8'hff);
    $display("test routing done");
  endtask : t_route

  task automatic t_restart();
    wr(8'h44, 32'h1);
    route(19'h10, 22'h0, 1'b0, 5'h00, 8'h0);
    route(19'h00, 22'h0, 1'b1, 5'h04, 8'h0);
    wr(8'h44, 32'h0);
    route(19'h10, 22'h0, 1'b0, 5'h04, 8'h0);
    $display("test restart override done");
  endtask : t_restart

  task automatic t_trip();
    wr(8'h40, 32'h1);
    trip(8'h11, 1'b0);
    chk({23'h0, target_shown, target_code}, 32'h111);
    trip(8'h22, 1'b0);
    chk({23'h0, target_shown, target_code}, 32'h111);
    repeat (20) @(posedge ref_clk);
    trip(8'h33, 1'b0);
    chk({23'h0, target_shown, target_code}, 32'h133);
    wr(8'h40, 32'h3e7);
    trip(8'h44, 1'b1);
    rd_chk(8'h4c, 32'h144, 1'b0);
    route(19'h7ffff, 22'h0, 1'b0, 5'h1f, 8'h0);
    repeat (40) @(posedge ref_clk);
    trip(8'h55, 1'b0);
    chk({23'h0, target_shown, target_code}, 32'h144);
    @(posedge ref_clk);
    trip_in <= '{trip_valid: 1'b0, trip_code: 8'h0, manual_clear: 1'b1};
    @(posedge ref_clk);
    trip_in <= '0;
    repeat (2) @(posedge ref_clk);
    chk({31'h0, target_shown}, 32'h0);
    trip(8'h66, 1'b0);
    chk({23'h0, target_shown, target_code}, 32'h166);
    $display("test trip target hold done");
  endtask : t_trip

  task automatic t_err();
    logic [31:0] r;
    logic        e;
    rd_chk(8'h50, 32'h0, 1'b1);
    apb(1'b1, 8'h01, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    rd_chk(8'h00, 32'h1, 1'b0);
    $display("test unmapped access done");
  endtask : t_err

  task automatic t_cfg();
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h0);
    route(19'h7ffff, 22'h0, 1'b0, 5'h0d, 8'h0);
    rd_chk(8'h48, 32'h0000000d, 1'b0);
    wr(8'h40, 32'h0);
    trip(8'h77, 1'b0);
    chk({23'h0, target_shown, target_code}, 32'h177);
    trip(8'h88, 1'b0);
    chk({23'h0, target_shown, target_code}, 32'h188);
    $display("test cleared words and zero hold done");
  endtask : t_cfg

  initial begin
    err_total = 0;
    checks_done = 0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sig_in = '0;
    trip_in = '0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_width();
    t_route();
    t_restart();
    t_trip();
    t_err();
    t_cfg();
    results();
  end
endmodule : tb_prm_matrix
`default_nettype wire
